/* design/mbrs_responder.sv */
`timescale 1ns/10ps
`include "mbrs_regs.svh"
module mbrs_responder #(
  parameter logic [7:0] UNIT_ADDR = 8'h00,
  parameter int         BAUD      = 9600,
  parameter int         MAXW      = `MBRS_MAX_WR_REGS,
  parameter int         GAP_CYC   = int'((64'(`MBRS_CLK_HZ) * `MBRS_GAP_TENTHS * `MBRS_CHAR_BITS
                                          + 64'(10 * BAUD) - 64'd1) / 64'(10 * BAUD))
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Received bytes from the serial receiver
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  // Reply bytes to the serial transmitter
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  input  wire logic        tx_ready,
  // Register lookup, answered combinationally for reg_addr
  output logic [15:0]      reg_addr,
  input  wire logic        reg_defined,
  input  wire logic        reg_is_coil,
  input  wire logic        reg_readable,
  input  wire logic        reg_writable,
  input  wire logic [15:0] reg_max,
  input  wire logic [15:0] reg_rdata,
  // Register writes
  output logic             wr_valid,
  output logic [15:0]      wr_addr,
  output logic [15:0]      wr_data,
  // Unit condition
  input  wire logic        remote_ok,
  input  wire logic        lockout,
  input  wire logic        exec_fail
);

  typedef struct packed {
    mbrs_pkg::mbrs_state_t  st;
    logic [7:0]             cnt;
    logic [23:0]            gap;
    logic [15:0]            crc;
    logic                   hit;
    logic [7:0]             fc;
    logic [15:0]            start;
    logic [15:0]            word;
    logic [7:0]             bcnt;
    logic [MAXW-1:0][15:0]  wbuf;
    logic [7:0]             err;
    logic [7:0]             idx;
    logic [7:0]             plen;
    logic [15:0]            raddr;
    logic                   txv;
    logic [7:0]             txd;
    logic                   wv;
    logic [15:0]            wa;
    logic [15:0]            wd;
  } mbrs_s_t;

  mbrs_s_t s;
  mbrs_s_t next_s;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MBRS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Length the function code defines; zero marks an unsupported code
  function automatic logic [8:0] exp_len(input logic [7:0] f, input logic [7:0] bc);
    case (f)
      `MBRS_FC_RD_COIL, `MBRS_FC_RD_HOLD, `MBRS_FC_WR_COIL, `MBRS_FC_WR_REG: exp_len = `MBRS_FIX_LEN;
      `MBRS_FC_WR_MULTI: exp_len = 9'(`MBRS_MULTI_HDR + {1'b0, bc});
      default: exp_len = 9'h000;
    endcase
  endfunction

  function automatic logic is_write(input logic [7:0] f);
    return f == `MBRS_FC_WR_COIL || f == `MBRS_FC_WR_REG || f == `MBRS_FC_WR_MULTI;
  endfunction

  logic        wr_fc;
  logic [15:0] nwords;
  logic [15:0] cur_wd;
  logic [7:0]  ni;
  logic [7:0]  wi;
  assign wr_fc  = is_write(s.fc);
  assign nwords = (s.fc == `MBRS_FC_RD_HOLD || s.fc == `MBRS_FC_WR_MULTI) ? s.word : 16'h0001;
  assign cur_wd = (s.fc == `MBRS_FC_WR_MULTI) ? s.wbuf[s.idx] : s.word;
  assign ni     = 8'(s.idx + 8'h01);
  assign wi     = 8'((s.cnt - 8'h07) >> 1);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // One decision process keeps frame capture, checks and reply in step
  always_comb begin
    next_s    = s;
    next_s.wv = 1'b0;
    case (s.st)
      mbrs_pkg::MBRS_IDLE: begin
        if (rx_valid) begin
          next_s.gap = 24'h000000;
          next_s.crc = crc_byte(s.crc, rx_data);
          if (s.cnt != 8'hFF) begin
            next_s.cnt = 8'(s.cnt + 8'h01);
          end
          case (s.cnt)
            8'h00: next_s.hit = (rx_data == UNIT_ADDR);
            8'h01: next_s.fc = rx_data;
            8'h02: next_s.start[15:8] = rx_data;
            8'h03: next_s.start[7:0] = rx_data;
            8'h04: next_s.word[15:8] = rx_data;
            8'h05: next_s.word[7:0] = rx_data;
            8'h06: next_s.bcnt = rx_data;
            default: begin
              // Surplus bytes beyond the buffer only feed the CRC and length checks
              if (s.fc == `MBRS_FC_WR_MULTI && 32'(wi) < MAXW) begin
                if (s.cnt[0]) begin
                  next_s.wbuf[wi][15:8] = rx_data;
                end else begin
                  next_s.wbuf[wi][7:0] = rx_data;
                end
              end
            end
          endcase
        end else if (s.cnt != 8'h00) begin
          if (s.gap == 24'(GAP_CYC - 1)) begin
            next_s.st = mbrs_pkg::MBRS_CHK;
          end else begin
            next_s.gap = 24'(s.gap + 24'h000001);
          end
        end
      end
      mbrs_pkg::MBRS_CHK: begin
        next_s.st    = mbrs_pkg::MBRS_TXLD;
        next_s.idx   = 8'h00;
        next_s.raddr = s.start;
        next_s.err   = `MBRS_ERR_NONE;
        if (!s.hit) begin
          next_s.st  = mbrs_pkg::MBRS_IDLE;
          next_s.cnt = 8'h00;
          next_s.gap = 24'h000000;
          next_s.crc = `MBRS_CRC_INIT;
        end else if (s.crc != 16'h0000) begin
          next_s.err = `MBRS_ERR_CRC;
        end else if (exp_len(s.fc, s.bcnt) == 9'h000) begin
          next_s.err = `MBRS_ERR_FUNC;
        end else if ({1'b0, s.cnt} != exp_len(s.fc, s.bcnt)) begin
          next_s.err = `MBRS_ERR_CRC;
        end else if ((s.fc == `MBRS_FC_RD_HOLD && (s.word == 16'h0000 || s.word > `MBRS_MAX_RD_REGS))
                  || (s.fc == `MBRS_FC_RD_COIL && s.word != 16'h0001)
                  || (s.fc == `MBRS_FC_WR_MULTI && (s.word == 16'h0000 || 32'(s.word) > MAXW
                      || {s.word[14:0], 1'b0} != {8'h00, s.bcnt}))) begin
          next_s.err = `MBRS_ERR_DATA;
        end else if (wr_fc && lockout) begin
          next_s.err = `MBRS_ERR_LOCAL;
        end else if (wr_fc && !remote_ok) begin
          next_s.err = `MBRS_ERR_DENIED;
        end else begin
          next_s.st = mbrs_pkg::MBRS_SCAN;
        end
      end
      mbrs_pkg::MBRS_SCAN: begin
        // One register per cycle; the first failing one decides the code
        if (!reg_defined) begin
          next_s.err = `MBRS_ERR_ADDR;
        end else if (reg_is_coil != (s.fc == `MBRS_FC_RD_COIL || s.fc == `MBRS_FC_WR_COIL)) begin
          next_s.err = `MBRS_ERR_FUNC;
        end else if (wr_fc ? !reg_writable : !reg_readable) begin
          next_s.err = `MBRS_ERR_DENIED;
        end else if ((s.fc == `MBRS_FC_WR_COIL && s.word != `MBRS_COIL_FALSE && s.word != `MBRS_COIL_TRUE)
                  || ((s.fc == `MBRS_FC_WR_REG || s.fc == `MBRS_FC_WR_MULTI) && cur_wd > reg_max)) begin
          next_s.err = `MBRS_ERR_DATA;
        end else if ({8'h00, ni} == nwords && wr_fc && exec_fail) begin
          next_s.err = `MBRS_ERR_EXEC;
        end
        if (next_s.err != `MBRS_ERR_NONE || {8'h00, ni} == nwords) begin
          next_s.st    = (next_s.err == `MBRS_ERR_NONE && wr_fc) ? mbrs_pkg::MBRS_WR : mbrs_pkg::MBRS_TXLD;
          next_s.idx   = 8'h00;
          next_s.raddr = s.start;
        end else begin
          next_s.idx   = ni;
          next_s.raddr = 16'(s.raddr + 16'h0001);
        end
      end
      mbrs_pkg::MBRS_WR: begin
        next_s.wv = 1'b1;
        next_s.wa = s.raddr;
        next_s.wd = cur_wd;
        if ({8'h00, ni} == nwords) begin
          next_s.st    = mbrs_pkg::MBRS_TXLD;
          next_s.idx   = 8'h00;
          next_s.raddr = s.start;
        end else begin
          next_s.idx   = ni;
          next_s.raddr = 16'(s.raddr + 16'h0001);
        end
      end
      mbrs_pkg::MBRS_TXLD: begin
        next_s.st  = mbrs_pkg::MBRS_TXW;
        next_s.txv = 1'b1;
        if (s.idx == 8'h00) begin
          next_s.crc  = `MBRS_CRC_INIT;
          next_s.plen = (s.err != `MBRS_ERR_NONE) ? `MBRS_EXC_PLEN :
                        (s.fc == `MBRS_FC_RD_HOLD) ? 8'(8'h03 + {s.word[6:0], 1'b0}) :
                        (s.fc == `MBRS_FC_RD_COIL) ? `MBRS_COIL_PLEN : `MBRS_ECHO_PLEN;
          next_s.txd  = UNIT_ADDR;
        end else if (s.idx == s.plen) begin
          next_s.txd = s.crc[7:0];
        end else if (s.idx > s.plen) begin
          next_s.txd = s.crc[15:8];
        end else if (s.idx == 8'h01) begin
          next_s.txd = (s.err != `MBRS_ERR_NONE) ? (s.fc | `MBRS_FC_EXC_FLAG) : s.fc;
        end else if (s.err != `MBRS_ERR_NONE) begin
          next_s.txd = s.err;
        end else if (s.fc == `MBRS_FC_RD_HOLD || s.fc == `MBRS_FC_RD_COIL) begin
          if (s.idx == 8'h02) begin
            next_s.txd = (s.fc == `MBRS_FC_RD_HOLD) ? {s.word[6:0], 1'b0} : `MBRS_COIL_BYTES;
          end else begin
            next_s.txd = s.idx[0] ? reg_rdata[15:8] : reg_rdata[7:0];
          end
        end else begin
          // Write echo; for a multi-write the word holds the register count
          case (s.idx)
            8'h02:   next_s.txd = s.start[15:8];
            8'h03:   next_s.txd = s.start[7:0];
            8'h04:   next_s.txd = s.word[15:8];
            default: next_s.txd = s.word[7:0];
          endcase
        end
      end
      mbrs_pkg::MBRS_TXW: begin
        if (tx_ready) begin
          next_s.txv   = 1'b0;
          next_s.idx   = ni;
          next_s.raddr = (ni >= 8'h03) ? 16'(s.start + {9'h000, 7'((ni - 8'h03) >> 1)}) : s.start;
          next_s.st    = mbrs_pkg::MBRS_TXLD;
          if (s.idx < s.plen) begin
            next_s.crc = crc_byte(s.crc, s.txd);
          end
          if (ni == 8'(s.plen + 8'h02)) begin
            next_s.st  = mbrs_pkg::MBRS_IDLE;
            next_s.cnt = 8'h00;
            next_s.gap = 24'h000000;
            next_s.crc = `MBRS_CRC_INIT;
          end
        end
      end
      default: next_s.st = mbrs_pkg::MBRS_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s     <= '0;
      s.crc <= `MBRS_CRC_INIT;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state flops
  assign tx_valid = s.txv;
  assign tx_data  = s.txd;
  assign reg_addr = s.raddr;
  assign wr_valid = s.wv;
  assign wr_addr  = s.wa;
  assign wr_data  = s.wd;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence tx_stall_s;
    tx_valid && !tx_ready;
  endsequence
  sequence tx_held_s;
    tx_valid && $stable(tx_data);
  endsequence

  tx_hold_a: assert property (@(posedge clk) disable iff (!rstn) tx_stall_s |=> tx_held_s)
    else $error("reply byte changed while stalled");
  crc_err_a: assert property (@(posedge clk) disable iff (!rstn)
    s.st == mbrs_pkg::MBRS_CHK && s.hit && s.crc != 16'h0000 |=> s.err == `MBRS_ERR_CRC)
    else $error("bad CRC not answered with code 05");
  lock_code_a: assert property (@(posedge clk) disable iff (!rstn)
    s.st == mbrs_pkg::MBRS_SCAN |-> !(wr_fc && lockout && $past(s.st) == mbrs_pkg::MBRS_CHK))
    else $error("write scanned during lockout");
  no_exec_a: assert property (@(posedge clk) disable iff (!rstn) wr_valid |-> s.err == `MBRS_ERR_NONE)
    else $error("write issued for a failed request");
  exc_fc_a: assert property (@(posedge clk) disable iff (!rstn)
    s.st == mbrs_pkg::MBRS_TXW && s.idx == 8'h01 && s.err != `MBRS_ERR_NONE |-> tx_data == (s.fc | 8'h80))
    else $error("exception function code wrong");
  crc_low_a: assert property (@(posedge clk) disable iff (!rstn)
    s.st == mbrs_pkg::MBRS_TXW && s.idx == s.plen |-> tx_data == s.crc[7:0])
    else $error("CRC low byte not sent first");
  rd_count_a: assert property (@(posedge clk) disable iff (!rstn)
    s.st == mbrs_pkg::MBRS_TXW && s.idx == 8'h02 && s.err == 8'h00 && s.fc == 8'h03
    |-> tx_data == 8'(s.word << 1))
    else $error("register read byte count wrong");
  coil_count_a: assert property (@(posedge clk) disable iff (!rstn)
    s.st == mbrs_pkg::MBRS_TXW && s.idx == 8'h02 && s.err == 8'h00 && s.fc == 8'h01 |-> tx_data == 8'h02)
    else $error("coil read byte count not two");
  addr_err_a: assert property (@(posedge clk) disable iff (!rstn)
    s.st == mbrs_pkg::MBRS_SCAN && !reg_defined |=> s.err == 8'h02 ##1 tx_valid)
    else $error("undefined address not answered with code 02");
  gap_end_a: assert property (@(posedge clk) disable iff (!rstn)
    s.st == mbrs_pkg::MBRS_CHK |-> $past(!rx_valid) && $past(s.gap) == 24'(GAP_CYC - 1))
    else $error("frame closed without a full idle gap");

endmodule // mbrs_responder

/* design/mbrs_regs.svh */
`ifndef MBRS_REGS_SVH
`define MBRS_REGS_SVH

// ----------------------------------------------------------------
// Function codes
// ----------------------------------------------------------------
`define MBRS_FC_RD_COIL   8'h01
`define MBRS_FC_RD_HOLD   8'h03
`define MBRS_FC_WR_COIL   8'h05
`define MBRS_FC_WR_REG    8'h06
`define MBRS_FC_WR_MULTI  8'h10
`define MBRS_FC_EXC_FLAG  8'h80

// ----------------------------------------------------------------
// Error codes
// ----------------------------------------------------------------
`define MBRS_ERR_NONE     8'h00
`define MBRS_ERR_FUNC     8'h01
`define MBRS_ERR_ADDR     8'h02
`define MBRS_ERR_DATA     8'h03
`define MBRS_ERR_EXEC     8'h04
`define MBRS_ERR_CRC      8'h05
`define MBRS_ERR_DENIED   8'h07
`define MBRS_ERR_LOCAL    8'h17

// ----------------------------------------------------------------
// CRC, coil words, lengths
// ----------------------------------------------------------------
`define MBRS_CRC_INIT     16'hFFFF
`define MBRS_CRC_POLY     16'hA001
`define MBRS_COIL_FALSE   16'h0000
`define MBRS_COIL_TRUE    16'hFF00
`define MBRS_COIL_BYTES   8'h02
`define MBRS_FIX_LEN      9'h008
`define MBRS_MULTI_HDR    9'h009
`define MBRS_MAX_RD_REGS  16'h007D
`define MBRS_MAX_WR_REGS  123
`define MBRS_EXC_PLEN     8'h03
`define MBRS_COIL_PLEN    8'h05
`define MBRS_ECHO_PLEN    8'h06

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MBRS_CLK_HZ       50000000
`define MBRS_GAP_TENTHS   35
`define MBRS_CHAR_BITS    11
`endif

/* design/mbrs_pkg.sv */
package mbrs_pkg;
  // Gray coded along receive, check, scan, write, transmit
  typedef enum logic [2:0] {
    MBRS_IDLE = 3'h0,
    MBRS_CHK  = 3'h1,
    MBRS_SCAN = 3'h3,
    MBRS_WR   = 3'h2,
    MBRS_TXLD = 3'h6,
    MBRS_TXW  = 3'h7
  } mbrs_state_t;
endpackage

/* tb/mbrs_host_model.sv */
`timescale 1ns/10ps
module mbrs_host_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Reply stream from the responder
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_data,
  output logic             tx_ready,
  // Bench control and observation
  input  wire logic        stall,
  input  wire logic        clear,
  output logic [15:0]      residue
);
  // One byte step of the reflected check over each reply byte
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
    end
    return r;
  endfunction

  // A busy host stalls; the responder must hold its byte meanwhile
  assign tx_ready = !stall;

  // Running check over each reply; low byte first makes a good frame end at zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      residue <= 16'hFFFF;
    end else if (clear) begin
      residue <= 16'hFFFF;
    end else if (tx_valid && tx_ready) begin
      residue <= crc_step(residue, tx_data);
    end
  end
endmodule // mbrs_host_model

/* tb/test_modbus_rtu_slave_responder.sv */
`timescale 1ns/10ps
module test_modbus_rtu_slave_responder;
  // ------------------------------
  // Signals and bench state
  // ------------------------------
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        rx_valid = 1'b0;
  logic [7:0]  rx_data = 8'h00;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        tx_ready;
  logic [15:0] reg_addr;
  logic        reg_defined;
  logic        reg_is_coil;
  logic        reg_readable;
  logic        reg_writable;
  logic [15:0] reg_max;
  logic [15:0] reg_rdata;
  logic        wr_valid;
  logic [15:0] wr_addr;
  logic [15:0] wr_data;
  logic        remote_ok = 1'b1;
  logic        lockout = 1'b0;
  logic        exec_fail = 1'b0;
  logic        stall = 1'b0;
  logic        clear = 1'b0;
  logic [15:0] residue;
  logic [31:0] seed = 32'h00000B09;
  logic [7:0]  req[$];
  logic [7:0]  rsp[$];
  logic [7:0]  exp_q[$];
  logic [31:0] wq[$];
  logic [15:0] v;
  int          num_errors = 0;
  int          comparisons = 0;
  int          tests = 0;

  // ------------------------------
  // Design and host model
  // ------------------------------
  // Short gap keeps frame ends quick in simulation
  mbrs_responder #(.UNIT_ADDR(8'h00), .MAXW(8), .GAP_CYC(20)) mbrs_responder_inst (
    .clk(clk), .rstn(rstn), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .reg_addr(reg_addr),
    .reg_defined(reg_defined), .reg_is_coil(reg_is_coil), .reg_readable(reg_readable),
    .reg_writable(reg_writable), .reg_max(reg_max), .reg_rdata(reg_rdata),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
    .remote_ok(remote_ok), .lockout(lockout), .exec_fail(exec_fail));
  mbrs_host_model mbrs_host_model_inst (
    .clk(clk), .rstn(rstn), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .stall(stall), .clear(clear), .residue(residue));

  // Clock at 50 MHz
  always #10 clk = ~clk;

  // Register map: 0x10-0x13 words, 0x20 coil, 0x30 read-only, 0x40 write-only
  always_comb begin
    reg_defined  = (reg_addr[15:2] == 14'h0004) || (reg_addr inside {16'h0020, 16'h0030, 16'h0040});
    reg_is_coil  = (reg_addr == 16'h0020);
    reg_readable = (reg_addr != 16'h0040);
    reg_writable = (reg_addr != 16'h0030);
    reg_max      = reg_is_coil ? 16'hFFFF : 16'hCCCC;
    reg_rdata    = {reg_addr[7:0] ^ 8'hA5, reg_addr[7:0]};
  end

  // Pseudo-random source for stalls and write values
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] r;
    r = x ^ (x << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction

  // Xorshift drives host stalls about a quarter of the time
  always @(negedge clk) begin
    seed  = xorshift(seed);
    stall = seed[0] & seed[1];
  end

  // ------------------------------
  // Checking
  // ------------------------------
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Each accepted byte or write is matched to the oldest note; a surplus can never match
  always @(posedge clk) begin
    if (rstn && tx_valid && tx_ready) begin
      chk(tx_data, (exp_q.size() != 0) ? exp_q.pop_front() : 33'h100000000);
    end
    if (rstn && wr_valid) begin
      chk({wr_addr, wr_data}, (wq.size() != 0) ? wq.pop_front() : 33'h100000000);
    end
  end

  task automatic results();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ------------------------------
  // Frame driver
  // ------------------------------
  // Own copy of the check, kept apart from the host model on purpose
  function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction

  // Sends req with its check appended, notes rsp, waits for the whole reply
  task automatic xfer(input logic [2:0] cond, input logic swap);
    logic [15:0] c;
    int          n;
    c = crc_of(req);
    if (swap) begin
      req = {req, c[15:8], c[7:0]};
    end else begin
      req = {req, c[7:0], c[15:8]};
    end
    // An empty note means no reply is due, so no check bytes either
    c = crc_of(rsp);
    if (rsp.size() != 0) begin
      rsp = {rsp, c[7:0], c[15:8]};
    end
    foreach (rsp[i]) exp_q.push_back(rsp[i]);
    {remote_ok, lockout, exec_fail} = cond;
    clear = 1'b1;
    @(negedge clk);
    clear = 1'b0;
    foreach (req[i]) begin
      rx_valid = 1'b1;
      rx_data = req[i];
      @(negedge clk);
      rx_valid = 1'b0;
      @(negedge clk);
    end
    // Wait at least past the frame gap so a stray reply is still seen
    n = 0;
    while ((exp_q.size() != 0 || n < 40) && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, exp_q.size(), 0);
      results();
    end
    repeat (4) @(negedge clk);
    chk(residue, (rsp.size() != 0) ? 33'h0 : 33'h0FFFF);
    chk(wq.size(), 33'h0);
    tests++;
    $display("test %0d done", tests);
  endtask

  // Exception reply: function plus 0x80 and the code
  task automatic err(input logic [2:0] cond, input logic [7:0] code, input logic swap);
    rsp = {8'h00, req[1] | 8'h80, code};
    xfer(cond, swap);
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  initial begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk({tx_valid, wr_valid, tx_data, reg_addr}, 33'h0);
    req = {8'h00, 8'h03, 8'h00, 8'h10, 8'h00, 8'h02};
    rsp = {8'h00, 8'h03, 8'h04, 8'hB5, 8'h10, 8'hB4, 8'h11};
    xfer(3'b100, 1'b0);
    req = {8'h00, 8'h01, 8'h00, 8'h20, 8'h00, 8'h01};
    rsp = {8'h00, 8'h01, 8'h02, 8'h85, 8'h20};
    xfer(3'b100, 1'b0);
    v = seed[15:0] % 16'hCCCD;
    req = {8'h00, 8'h06, 8'h00, 8'h11, v[15:8], v[7:0]};
    rsp = req;
    wq.push_back({16'h0011, v});
    xfer(3'b100, 1'b0);
    req = {8'h00, 8'h10, 8'h00, 8'h12, 8'h00, 8'h02, 8'h04, 8'h11, 8'h22, 8'h33, 8'h44};
    rsp = {8'h00, 8'h10, 8'h00, 8'h12, 8'h00, 8'h02};
    wq = {32'h00121122, 32'h00133344};
    xfer(3'b100, 1'b0);
    for (int i = 0; i < 2; i++) begin
      v = i ? 16'hFF00 : 16'h0000;
      req = {8'h00, 8'h05, 8'h00, 8'h20, v[15:8], v[7:0]};
      rsp = req;
      wq.push_back({16'h0020, v});
      xfer(3'b100, 1'b0);
    end
    // Refused requests below, apart from one register read under lockout: none may write
    // A frame for another unit gets no reply at all
    req = {8'h05, 8'h06, 8'h00, 8'h11, 8'h00, 8'h01};
    rsp.delete();
    xfer(3'b100, 1'b0);
    req = {8'h00, 8'h05, 8'h00, 8'h20, 8'h12, 8'h34};
    err(3'b100, 8'h03, 1'b0);
    req = {8'h00, 8'h03, 8'h00, 8'h10, 8'h00, 8'h01};
    err(3'b100, 8'h05, 1'b1);
    req = {8'h00, 8'h07, 8'h00, 8'h10, 8'h00, 8'h01};
    err(3'b100, 8'h01, 1'b0);
    req = {8'h00, 8'h01, 8'h00, 8'h10, 8'h00, 8'h01};
    err(3'b100, 8'h01, 1'b0);
    req = {8'h00, 8'h03, 8'h00, 8'h99, 8'h00, 8'h01};
    err(3'b100, 8'h02, 1'b0);
    req = {8'h00, 8'h06, 8'h00, 8'h11, 8'hE0, 8'h00};
    err(3'b100, 8'h03, 1'b0);
    req = {8'h00, 8'h06, 8'h00, 8'h11, 8'h00, 8'h01};
    err(3'b101, 8'h04, 1'b0);
    req = {8'h00, 8'h06, 8'h00, 8'h30, 8'h00, 8'h01};
    err(3'b100, 8'h07, 1'b0);
    req = {8'h00, 8'h06, 8'h00, 8'h11, 8'h00, 8'h01};
    err(3'b000, 8'h07, 1'b0);
    req = {8'h00, 8'h03, 8'h00, 8'h40, 8'h00, 8'h01};
    err(3'b100, 8'h07, 1'b0);
    req = {8'h00, 8'h10, 8'h00, 8'h12, 8'h00, 8'h01, 8'h02, 8'h00, 8'h01};
    err(3'b010, 8'h17, 1'b0);
    req = {8'h00, 8'h03, 8'h00, 8'h13, 8'h00, 8'h01};
    rsp = {8'h00, 8'h03, 8'h02, 8'hB6, 8'h13};
    xfer(3'b110, 1'b0);
    req = {8'h00, 8'h03, 8'h00, 8'h20, 8'h00, 8'h01};
    err(3'b100, 8'h01, 1'b0);
    req = {8'h00, 8'h03, 8'h00, 8'h10, 8'h00, 8'h01, 8'h00};
    err(3'b100, 8'h05, 1'b0);
    results();
  end
endmodule // test_modbus_rtu_slave_responder
